// >>> shared/ahl_map.svh
`ifndef AHL_MAP_SVH
`define AHL_MAP_SVH
// ****************
// link characters
// ****************
`define AHL_ENQ      8'h05
`define AHL_AT       8'h40
`define AHL_STAR     8'h2A
`define AHL_CR       8'h0D
// ****************
// modes and limits
// ****************
`define AHL_NATIVE   3'h5
`define AHL_P2P_MIN  3'h2
`define AHL_MP_MIN   3'h6
// ****************
// serial format after reset
// ****************
`define AHL_BAUD_RST 17'h0_9600
`define AHL_DBIT_RST 4'h8
`define AHL_SBIT_RST 2'h1
`define AHL_PAR_RST  2'h0
// ****************
// error headers
// ****************
`define AHL_CERR0    8'h45
`define AHL_CERR1    8'h52
`define AHL_FERR0    8'h46
`define AHL_FERR1    8'h45
`endif

// >>> shared/ahl_pkg.sv
package ahl_pkg;
  // ****************
  // states
  // ****************
  typedef enum logic [3:0] {
    S_IDLE, S_ECHO, S_P2P, S_MP, S_WAIT, S_AT, S_ID1, S_ID2,
    S_H0, S_H1, S_DATA, S_F1, S_F2, S_STAR, S_CR
  } ahl_state_e;
  // ****************
  // serial format
  // ****************
  typedef struct packed {
    logic [16:0] baud;
    logic [3:0]  dbits;
    logic [1:0]  sbits;
    logic [1:0]  parity;
  } ahl_fmt_s;
  // ****************
  // block state
  // ****************
  typedef struct packed {
    ahl_state_e st;
    logic       mp;
    logic       err;
    logic       ferr;
    logic       nd;
    logic       star;
    logic [2:0] cnt;
    logic [3:0] idh;
    logic [7:0] x;
    logic [7:0] tx;
    logic [7:0] p1;
    logic [7:0] p2;
    logic [7:0] h0;
    logic [7:0] h1;
    logic       tv;
    logic [7:0] td;
    ahl_fmt_s   fmt;
    logic       cv;
    logic [7:0] cc;
    logic       ce;
    logic       cb;
  } ahl_reg_s;
endpackage

// >>> rtl/ahl_responder.sv
`timescale 1ns/10ps
`default_nettype none
`include "ahl_map.svh"
// Notes on behaviour
// RL1 - link format resets to 38400 baud, 8 data, 1 stop, no parity.
// RL2 - point-to-point frame: two-char header, data, then '*' and CR.
// RL3 - each binary byte travels as two ASCII hex characters.
// RL4 - host opens a point-to-point session with a single 05 hex.
// RL5 - device echoes 05; host then sends its command at once.
// RL6 - accepted command answers with same header, data, terminator; session ends.
// RL7 - unknown header or missing channel gets an error response.
// RL8 - multi-point frame: '@', hex ID, body, two-char check, terminator.
// RL9 - check value is XOR of all chars from '@' to last data.
// RL10 - in automatic mode a "00" check field skips verification.
// RL11 - protocol select 5 disables the wildcard; check must be right.
// RL12 - host sends no 05 in multi-point; one command, one answer.
// RL13 - only a matching ID gets an answer; otherwise line stays undriven.
// RL14 - every controller on a shared network has a distinct ID.
// RL15 - framing is detected per frame and the reply uses the same.
// RL16 - multi-point reply: '@', own ID, header, data, fresh check, terminator.
// RL17 - responses are generated autonomously, without the application.
// RL18 - wrong check value on a multi-point command gives a framing error.
// RL19 - a new '@' or 05 before the terminator restarts parsing.
module ahl_responder
  import ahl_pkg::*;
(
  // clock and reset
  input  wire logic       i_clock,
  input  wire logic       i_resetn,
  // received characters
  input  wire logic       i_rx_valid,
  input  wire logic [7:0] i_rx_data,
  // transmitted characters
  output logic            o_tx_valid,
  output logic [7:0]      o_tx_data,
  input  wire logic       i_tx_ready,
  output logic            o_tx_en,
  // configuration
  input  wire logic [7:0] i_own_id,
  input  wire logic [2:0] i_proto_sel,
  input  wire logic       i_fmt_wr,
  input  wire ahl_fmt_s   i_fmt,
  output ahl_fmt_s        o_link_fmt,
  // command toward handler
  output logic            o_cmd_valid,
  output logic [7:0]      o_cmd_char,
  output logic            o_cmd_end,
  output logic            o_cmd_bad,
  // answer from handler
  input  wire logic       i_rsp_valid,
  input  wire logic [7:0] i_rsp_char,
  input  wire logic       i_rsp_last,
  input  wire logic       i_rsp_err,
  input  wire logic       i_rsp_empty,
  output logic            o_rsp_ready
);
  // ****************
  // hex helpers
  // ****************
  function automatic logic [3:0] hexv(input logic [7:0] c);
    hexv = (c >= 8'h41) ? 4'(c[3:0] + 4'h9) : c[3:0]; // [RL3]
  endfunction

  function automatic logic [7:0] hexc(input logic [3:0] v);
    hexc = (v > 4'h9) ? {4'h4, 4'(v - 4'h9)} : {4'h3, v}; // [RL3]
  endfunction

  localparam ahl_reg_s RST = '{
    st: S_IDLE,
    fmt: '{`AHL_BAUD_RST, `AHL_DBIT_RST, `AHL_SBIT_RST, `AHL_PAR_RST},
    default: '0
  };

  ahl_reg_s   r_reg;
  ahl_reg_s   r_next;
  logic [7:0] c;
  logic [7:0] fcs_calc;
  logic [7:0] fcs_rcv;
  logic       wild_ok;
  logic       fcs_ok;
  logic       in_tx;
  logic       ld;
  logic [7:0] ch;
  ahl_state_e nxt;

  assign c        = i_rx_data;
  assign fcs_calc = r_reg.x ^ r_reg.p1 ^ r_reg.p2;                   // [RL9]
  assign fcs_rcv  = {hexv(r_reg.p2), hexv(r_reg.p1)};
  assign wild_ok  = (fcs_rcv == 8'h00) && (i_proto_sel != `AHL_NATIVE); // [RL10] [RL11]
  assign fcs_ok   = !r_reg.mp || (fcs_rcv == fcs_calc) || wild_ok;   // [RL18]
  assign in_tx    = r_reg.st inside {S_AT, S_ID1, S_ID2, S_H0, S_H1,
                                     S_DATA, S_F1, S_F2, S_STAR, S_CR};

  // ****************
  // next state
  // ****************
  always_comb begin
    r_next      = r_reg;
    r_next.cv   = 1'b0;
    r_next.ce   = 1'b0;
    o_rsp_ready = 1'b0;
    ld          = 1'b0;
    ch          = 8'h00;
    nxt         = S_IDLE;
    if (r_reg.tv && i_tx_ready) begin
      r_next.tv = 1'b0;
    end
    if (i_fmt_wr) begin
      r_next.fmt = i_fmt; // [RL1]
    end
    unique case (r_reg.st)
      S_IDLE, S_P2P, S_MP: begin
        if (i_rx_valid) begin
          if (c == `AHL_ENQ) begin
            r_next.st = S_ECHO; // [RL4] [RL19]
          end else if (c == `AHL_AT) begin
            r_next.st   = S_MP; // [RL12] [RL15] [RL19]
            r_next.mp   = 1'b1;
            r_next.cnt  = 3'h0;
            r_next.star = 1'b0;
            r_next.x    = c;
          end else if (r_reg.st == S_IDLE) begin
            r_next.st = S_IDLE;
          end else if (r_reg.star) begin
            if (c == `AHL_CR &&
                r_reg.cnt >= (r_reg.mp ? `AHL_MP_MIN : `AHL_P2P_MIN)) begin
              r_next.ce   = 1'b1; // [RL2] [RL8]
              r_next.cb   = !fcs_ok;
              r_next.ferr = !fcs_ok; // [RL18]
              r_next.err  = 1'b0;
              r_next.st   = fcs_ok ? S_WAIT : S_AT;
            end else begin
              r_next.st = S_IDLE;
            end
          end else if (c == `AHL_STAR) begin
            r_next.star = 1'b1;
          end else begin
            r_next.cnt = (r_reg.cnt == 3'h7) ? r_reg.cnt : 3'(r_reg.cnt + 3'h1);
            r_next.x   = r_reg.x ^ c; // [RL9]
            if (!r_reg.mp) begin
              if (r_reg.cnt == 3'h0) begin
                r_next.h0 = c;
              end
              if (r_reg.cnt == 3'h1) begin
                r_next.h1 = c;
              end
              r_next.cv = 1'b1;
              r_next.cc = c;
            end else begin
              r_next.p1 = c;
              r_next.p2 = r_reg.p1;
              if (r_reg.cnt == 3'h0) begin
                r_next.idh = hexv(c); // [RL8]
              end
              if (r_reg.cnt == 3'h1 && {r_reg.idh, hexv(c)} != i_own_id) begin
                r_next.st = S_IDLE; // [RL13] [RL14]
              end
              if (r_reg.cnt == 3'h2) begin
                r_next.h0 = c;
              end
              if (r_reg.cnt == 3'h3) begin
                r_next.h1 = c;
              end
              if (r_reg.cnt >= 3'h4) begin
                r_next.cv = 1'b1;
                r_next.cc = r_reg.p2;
              end
            end
          end
        end
      end
      S_ECHO: begin
        if (!r_reg.tv) begin
          r_next.tv   = 1'b1; // [RL5]
          r_next.td   = `AHL_ENQ;
          r_next.st   = S_P2P;
          r_next.mp   = 1'b0;
          r_next.cnt  = 3'h0;
          r_next.star = 1'b0;
        end
      end
      S_WAIT: begin
        if (i_rsp_valid) begin
          o_rsp_ready = i_rsp_err || i_rsp_empty;
          r_next.err  = i_rsp_err; // [RL7]
          r_next.nd   = i_rsp_err || i_rsp_empty;
          r_next.st   = r_reg.mp ? S_AT : S_H0; // [RL15] [RL17]
        end
      end
      S_AT: begin
        ld  = 1'b1;
        ch  = `AHL_AT; // [RL16]
        nxt = S_ID1;
      end
      S_ID1: begin
        ld  = 1'b1;
        ch  = hexc(i_own_id[7:4]); // [RL16]
        nxt = S_ID2;
      end
      S_ID2: begin
        ld  = 1'b1;
        ch  = hexc(i_own_id[3:0]);
        nxt = S_H0;
      end
      S_H0: begin
        ld  = 1'b1;
        ch  = r_reg.ferr ? `AHL_FERR0 : (r_reg.err ? `AHL_CERR0 : r_reg.h0); // [RL6] [RL7]
        nxt = S_H1;
      end
      S_H1: begin
        ld  = 1'b1;
        ch  = r_reg.ferr ? `AHL_FERR1 : (r_reg.err ? `AHL_CERR1 : r_reg.h1);
        nxt = (r_reg.nd || r_reg.ferr) ? (r_reg.mp ? S_F1 : S_STAR) : S_DATA;
      end
      S_DATA: begin
        ld          = i_rsp_valid;
        o_rsp_ready = i_rsp_valid && !r_reg.tv;
        ch          = i_rsp_char;
        nxt         = !i_rsp_last ? S_DATA : (r_reg.mp ? S_F1 : S_STAR);
      end
      S_F1: begin
        ld  = 1'b1;
        ch  = hexc(r_reg.tx[7:4]); // [RL9] [RL16]
        nxt = S_F2;
      end
      S_F2: begin
        ld  = 1'b1;
        ch  = hexc(r_reg.tx[3:0]);
        nxt = S_STAR;
      end
      S_STAR: begin
        ld  = 1'b1;
        ch  = `AHL_STAR; // [RL2]
        nxt = S_CR;
      end
      S_CR: begin
        ld  = 1'b1;
        ch  = `AHL_CR; // [RL2] [RL6]
        nxt = S_IDLE;
      end
    endcase
    if (ld && !r_reg.tv) begin
      r_next.tv = 1'b1; // [RL17]
      r_next.td = ch;
      r_next.st = nxt;
      if (r_reg.st inside {S_AT, S_ID1, S_ID2, S_H0, S_H1, S_DATA}) begin
        r_next.tx = ((r_reg.st == S_AT) ? 8'h00 : r_reg.tx) ^ ch; // [RL9]
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      r_reg <= RST; // [RL1]
    end else begin
      r_reg <= r_next;
    end
  end

  // ****************
  // outputs
  // ****************
  assign o_tx_valid  = r_reg.tv;
  assign o_tx_data   = r_reg.td;
  assign o_tx_en     = r_reg.tv || in_tx; // [RL13]
  assign o_link_fmt  = r_reg.fmt;
  assign o_cmd_valid = r_reg.cv;
  assign o_cmd_char  = r_reg.cc;
  assign o_cmd_end   = r_reg.ce;
  assign o_cmd_bad   = r_reg.cb;

  // ****************
  // assertions
  // ****************
  default clocking cb_main @(posedge i_clock); endclocking
  default disable iff (!i_resetn);

  logic rx_idle_enq;
  logic id_miss;
  assign rx_idle_enq = i_rx_valid && c == `AHL_ENQ && r_reg.st == S_IDLE && !r_reg.tv;
  assign id_miss     = r_reg.st == S_MP && i_rx_valid && !r_reg.star && r_reg.cnt == 3'h1 &&
                       c != `AHL_AT && c != `AHL_ENQ && {r_reg.idh, hexv(c)} != i_own_id;

  property p_echo;
    rx_idle_enq |=> ##1 (o_tx_valid && o_tx_data == `AHL_ENQ);
  endproperty
  a_echo: assert property (p_echo) else $error("ctrl-e not echoed"); // [RL5]

  property p_silent;
    id_miss |=> (r_reg.st == S_IDLE && !in_tx);
  endproperty
  a_silent: assert property (p_silent) else $error("answered foreign id"); // [RL13]

  property p_ferr;
    (o_cmd_end && o_cmd_bad) |-> (r_reg.st == S_AT && r_reg.ferr);
  endproperty
  a_ferr: assert property (p_ferr) else $error("bad check not reported"); // [RL18]

  property p_native;
    (r_reg.st == S_MP && r_reg.star && i_rx_valid && c == `AHL_CR &&
     r_reg.cnt >= `AHL_MP_MIN && i_proto_sel == `AHL_NATIVE &&
     fcs_rcv != fcs_calc) |=> o_cmd_bad;
  endproperty
  a_native: assert property (p_native) else $error("wildcard in native mode"); // [RL11]

  property p_wild;
    (r_reg.st == S_MP && r_reg.star && i_rx_valid && c == `AHL_CR &&
     r_reg.cnt >= `AHL_MP_MIN && i_proto_sel != `AHL_NATIVE &&
     fcs_rcv == 8'h00) |=> (o_cmd_end && !o_cmd_bad);
  endproperty
  a_wild: assert property (p_wild) else $error("wildcard refused"); // [RL10]

  property p_at;
    (r_reg.st == S_AT && !r_reg.tv) |=> (o_tx_data == `AHL_AT && r_reg.st == S_ID1);
  endproperty
  a_at: assert property (p_at) else $error("reply lacks leading at"); // [RL16]

  property p_term;
    (r_reg.st == S_STAR && !r_reg.tv) |=> (o_tx_data == `AHL_STAR && r_reg.st == S_CR);
  endproperty
  a_term: assert property (p_term) else $error("terminator wrong"); // [RL2]

  property p_hdr;
    (r_reg.st == S_H0 && !r_reg.tv && !r_reg.err && !r_reg.ferr) |=>
      (o_tx_data == $past(r_reg.h0) && o_tx_en);
  endproperty
  a_hdr: assert property (p_hdr) else $error("reply header differs"); // [RL6]

  property p_restart;
    (r_reg.st inside {S_P2P, S_MP} && i_rx_valid && c == `AHL_AT) |=>
      (r_reg.st == S_MP && r_reg.cnt == 3'h0);
  endproperty
  a_restart: assert property (p_restart) else $error("no restart on at"); // [RL19]

  c_p2p: cover property (o_cmd_end && !o_cmd_bad && !r_reg.mp);
  c_mp: cover property (o_cmd_end && !o_cmd_bad && r_reg.mp);
  c_ferr: cover property (o_cmd_end && o_cmd_bad);
  c_cerr: cover property (r_reg.st == S_H0 && r_reg.err);
endmodule
`default_nettype wire

// >>> tb/ahl_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module ahl_host_model (
  // clock
  input  wire logic       i_clock,
  // pacing
  input  wire logic       i_slow,
  // toward the responder
  output logic            o_rx_valid,
  output logic [7:0]      o_rx_data,
  // from the responder
  input  wire logic       i_tx_valid,
  input  wire logic [7:0] i_tx_data,
  output logic            o_tx_ready
);
  logic [7:0] q[$];
  initial begin
    o_rx_valid = 1'b0;
    o_rx_data  = 8'h00;
    o_tx_ready = 1'b0;
  end
  // ****************
  // receiver of the reply, a slow host takes every other cycle
  // ****************
  always @(posedge i_clock) begin
    if (i_tx_valid === 1'b1 && o_tx_ready) q.push_back(i_tx_data);
    #1 o_tx_ready = i_slow ? ~o_tx_ready : 1'b1;
  end
  // ****************
  // sender, data line turned over once released
  // ****************
  task automatic put(input string s);
    foreach (s[i]) begin
      @(posedge i_clock);
      #1 o_rx_valid = 1'b1;
      o_rx_data = s[i];
    end
    @(posedge i_clock);
    #1 o_rx_valid = 1'b0;
    o_rx_data = ~o_rx_data;
  endtask
  task automatic send(input string s, input bit p2p);
    int n;
    if (p2p) begin
      put("\005");
      // wait for the echo, then go at once
      for (n = 0; n < 300 && q.size() == 0; n++) @(posedge i_clock);
    end
    put(s);
  endtask
endmodule
`default_nettype wire

// >>> tb/ahl_responder_tb.sv
`timescale 1ns/10ps
`default_nettype none
module ahl_responder_tb
  import ahl_pkg::*;
;
  typedef struct {
    logic [2:0] pr;
    bit         p2p;
    string      cmd;
    byte        k;
    string      body;
    bit         bad;
    string      exp;
  } ahl_row_s;
  logic       i_clock = 1'b0;
  logic       i_resetn;
  logic       rx_valid, tx_valid, tx_ready, tx_en, fmt_wr, slow, en_seen;
  logic       cmd_valid, cmd_end, cmd_bad, rsp_valid, rsp_last, rsp_err, rsp_empty, rsp_ready;
  logic [7:0] rx_data, tx_data, own_id, cmd_char, rsp_char;
  logic [2:0] proto;
  ahl_fmt_s   fmt, link_fmt;
  int         n_errors, compares;
  logic [7:0] cmdq[$];
  ahl_row_s   rows[10];
  always #20 i_clock = ~i_clock;
  ahl_responder dut (
    .i_clock(i_clock), .i_resetn(i_resetn), .i_rx_valid(rx_valid), .i_rx_data(rx_data),
    .o_tx_valid(tx_valid), .o_tx_data(tx_data), .i_tx_ready(tx_ready), .o_tx_en(tx_en),
    .i_own_id(own_id), .i_proto_sel(proto), .i_fmt_wr(fmt_wr), .i_fmt(fmt),
    .o_link_fmt(link_fmt), .o_cmd_valid(cmd_valid), .o_cmd_char(cmd_char),
    .o_cmd_end(cmd_end), .o_cmd_bad(cmd_bad), .i_rsp_valid(rsp_valid),
    .i_rsp_char(rsp_char), .i_rsp_last(rsp_last), .i_rsp_err(rsp_err),
    .i_rsp_empty(rsp_empty), .o_rsp_ready(rsp_ready));
  ahl_host_model host (
    .i_clock(i_clock), .i_slow(slow), .o_rx_valid(rx_valid), .o_rx_data(rx_data),
    .i_tx_valid(tx_valid), .i_tx_data(tx_data), .o_tx_ready(tx_ready));
  always @(posedge i_clock) begin
    if (cmd_valid === 1'b1) cmdq.push_back(cmd_char);
    if (tx_en === 1'b1) en_seen = 1'b1;
  end
  // ****************
  // helpers
  // ****************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("compares=%0d n_errors=%0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic beat(input logic [7:0] c, input logic l, input logic e, input logic m);
    @(posedge i_clock);
    #1 rsp_valid = 1'b1;
    rsp_char = c;
    rsp_last = l;
    rsp_err = e;
    rsp_empty = m;
    do @(negedge i_clock); while (rsp_ready !== 1'b1);
    @(posedge i_clock);
    #1 rsp_valid = 1'b0;
  endtask
  task automatic handle(input int i);
    int n;
    if (rows[i].body.len() > 0) begin
      for (n = 0; n < 400 && cmd_end !== 1'b1; n++) @(negedge i_clock);
      chk(cmd_end, 1'b1);
      chk(cmd_bad, rows[i].bad);
      case (rows[i].k)
        "E": beat(8'h00, 1'b1, 1'b0, 1'b1);
        "R": beat(8'h00, 1'b1, 1'b1, 1'b0);
        "D": begin
          beat("1", 1'b0, 1'b0, 1'b0);
          beat("2", 1'b1, 1'b0, 1'b0);
        end
        default: ;
      endcase
    end
  endtask
  task automatic run(input int i);
    int n;
    proto = rows[i].pr;
    slow = i[0];
    cmdq.delete();
    host.q.delete();
    en_seen = 1'b0;
    fork
      host.send(rows[i].cmd, rows[i].p2p);
      handle(i);
    join
    for (n = 0; n < 400 && host.q.size() < rows[i].exp.len(); n++) @(posedge i_clock);
    repeat (30) @(posedge i_clock);
    #1 chk(host.q.size(), rows[i].exp.len());
    chk(en_seen, rows[i].exp.len() > 0);
    foreach (rows[i].exp[j]) chk(host.q[j], rows[i].exp[j]);
    chk(cmdq.size(), rows[i].body.len());
    foreach (rows[i].body[j]) chk(cmdq[j], rows[i].body[j]);
  endtask
  // ****************
  // sequence
  // ****************
  initial begin
    i_resetn = 1'b0;
    {fmt_wr, slow, en_seen, rsp_valid, rsp_last, rsp_err, rsp_empty} = 7'h00;
    {rsp_char, proto, fmt} = '0;
    own_id = 8'h01;
    n_errors = 0;
    compares = 0;
    rows[0] = '{3'h0, 1'b0, "@01TS00*\015", "E", "TS", 1'b0, "@01TS46*\015"};
    rows[1] = '{3'h5, 1'b0, "@01TS00*\015", "N", "TS", 1'b1, "@01FE42*\015"};
    rows[2] = '{3'h5, 1'b0, "@01TS46*\015", "E", "TS", 1'b0, "@01TS46*\015"};
    rows[3] = '{3'h0, 1'b0, "@02TS00*\015", "N", "", 1'b0, ""};
    rows[4] = '{3'h0, 1'b1, "TS*\015", "E", "TS", 1'b0, "\005TS*\015"};
    rows[5] = '{3'h0, 1'b0, "@01XX00*\015", "R", "XX", 1'b0, "@01ER56*\015"};
    rows[6] = '{3'h0, 1'b0, "@01RD00*\015", "D", "RD", 1'b0, "@01RD1254*\015"};
    rows[7] = '{3'h0, 1'b0, "@01T@01TS00*\015", "E", "TS", 1'b0, "@01TS46*\015"};
    rows[8] = '{3'h0, 1'b1, "XX*\015", "R", "XX", 1'b0, "\005ER*\015"};
    rows[9] = '{3'h5, 1'b0, "@01MS5F*\015", "E", "MS", 1'b0, "@01MS5F*\015"};
    repeat (20) @(posedge i_clock);
    #1 i_resetn = 1'b1;
    chk(32'(link_fmt), 32'({17'h0_9600, 4'h8, 2'h1, 2'h0}));
    foreach (rows[i]) run(i);
    // format change, then a reset between runs restores it
    @(posedge i_clock);
    #1 fmt = '{17'h0_4B00, 4'h7, 2'h2, 2'h1};
    fmt_wr = 1'b1;
    @(posedge i_clock);
    #1 fmt_wr = 1'b0;
    chk(32'(link_fmt), 32'(fmt));
    i_resetn = 1'b0;
    #1 chk(32'(link_fmt), 32'({17'h0_9600, 4'h8, 2'h1, 2'h0}));
    chk(tx_en, 1'b0);
    repeat (3) @(posedge i_clock);
    #1 i_resetn = 1'b1;
    run(0);
    final_report();
  end
  initial begin
    #(1_000_000);
    n_errors++;
    final_report();
  end
endmodule
`default_nettype wire
